// *** rtl/standard_event_status_logic.sv ***
// Purpose: Event status register, enable mask, operation-complete handshake and identification reply.
// Assumes: Command strobes and event inputs come from logic on clk; pins are synchronised by the caller.
// Notes: The register powers up with the power-on event set.
// Summary of operation
// - Read returns value, then clears register.
// - Bit 0 sets when operations finish.
// - Bits 3,4,5 set on errors.
// - Bit 7 sets at power on.
// - Enable mask gates each bit to request.
// - Operation-complete command clears bit 0.
// - Completion query waits, then answers 1.
// - Identification returns comma-separated four-field string.
// - Request needs summary bit 5 enabled too.
// - Clear-status command clears all status.
module standard_event_status_logic
  import event_status_pkg::*;
#(
  // The default identification text is arbitrary.
  parameter logic [8*ID_CHARS-1:0] ID_STRING = "MAKER,M1,SN1,V1 "
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ops_done,
  input wire logic dev_error,
  input wire logic exec_error,
  input wire logic cmd_error,
  input wire logic read_status,
  input wire logic complete_clear_cmd,
  input wire logic complete_query,
  input wire logic id_query,
  input wire logic clear_status_command,
  input wire logic mask_write,
  input wire logic [7:0] mask_data,
  input wire logic request_enable_write,
  input wire logic [7:0] request_enable_data,
  output logic [7:0] event_status_register,
  output logic [7:0] event_enable_mask,
  output logic [7:0] service_request_enable,
  output logic event_summary_bit,
  output logic service_request,
  output logic [7:0] reply_data,
  output logic reply_valid,
  output logic bus_busy,
  output logic clear_others
);
  logic [7:0] evt_r;
  logic [7:0] evt_nxt;
  logic [7:0] sets;
  logic [7:0] mask_r;
  logic [7:0] mask_nxt;
  logic [7:0] req_en_r;
  logic [7:0] req_en_nxt;
  logic clr_r;
  logic clr_nxt;
  query_state_t st_r;
  query_state_t st_nxt;
  logic [4:0] idx_r;
  logic [4:0] idx_nxt;
  logic [7:0] data_r;
  logic [7:0] data_nxt;
  logic valid_r;
  logic valid_nxt;
  logic read_taken;

  // A read is only taken while no query holds the bus, so a refused read loses nothing.
  assign read_taken = read_status && (st_r == Q_IDLE);

  // Event register: clears first, then new events, so a set always wins.
  always_comb begin
    sets = 8'h00;
    sets[BIT_DONE] = ops_done;
    sets[BIT_DDE] = dev_error;
    sets[BIT_EXE] = exec_error;
    sets[BIT_CME] = cmd_error;
    evt_nxt = evt_r;
    if (read_taken) begin
      evt_nxt = 8'h00;
    end
    if (clear_status_command) begin
      evt_nxt = 8'h00;
    end
    if (complete_clear_cmd) begin
      evt_nxt[BIT_DONE] = 1'b0;
    end
    evt_nxt = (evt_nxt | sets) & EVT_USED;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      evt_r <= EVT_RESET;
    end else begin
      evt_r <= evt_nxt;
    end
  end

  // Event enable mask.
  always_comb begin
    mask_nxt = mask_r;
    if (mask_write) begin
      mask_nxt = mask_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mask_r <= MASK_RESET;
    end else begin
      mask_r <= mask_nxt;
    end
  end

  // Service request enable.
  always_comb begin
    req_en_nxt = req_en_r;
    if (request_enable_write) begin
      req_en_nxt = request_enable_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      req_en_r <= REQ_EN_RESET;
    end else begin
      req_en_r <= req_en_nxt;
    end
  end

  // One-cycle pulse telling the other status registers to clear.
  always_comb begin
    clr_nxt = clear_status_command;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      clr_r <= 1'b0;
    end else begin
      clr_r <= clr_nxt;
    end
  end

  // Query state: a read has priority over a completion query, which has priority over identification.
  always_comb begin
    st_nxt = st_r;
    idx_nxt = idx_r;
    case (st_r)
      Q_IDLE: begin
        if (read_status) begin
          st_nxt = Q_IDLE;
        end else if (complete_query) begin
          st_nxt = Q_DONE_WAIT;
        end else if (id_query) begin
          st_nxt = Q_ID_SEND;
          idx_nxt = IDX_RESET;
        end
      end
      Q_DONE_WAIT: begin
        // The bus stays held until the flag is seen set.
        if (evt_r[BIT_DONE]) begin
          st_nxt = Q_IDLE;
        end
      end
      Q_ID_SEND: begin
        idx_nxt = idx_r + 5'h01;
        if (int'(idx_r) == ID_CHARS-1) begin
          st_nxt = Q_IDLE;
        end
      end
      default: begin
        st_nxt = Q_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_r <= Q_IDLE;
      idx_r <= IDX_RESET;
    end else begin
      st_r <= st_nxt;
      idx_r <= idx_nxt;
    end
  end

  // Reply byte and its one-cycle valid.
  always_comb begin
    data_nxt = data_r;
    valid_nxt = 1'b0;
    case (st_r)
      Q_IDLE: begin
        if (read_taken) begin
          data_nxt = evt_r;
          valid_nxt = 1'b1;
        end
      end
      Q_DONE_WAIT: begin
        if (evt_r[BIT_DONE]) begin
          data_nxt = DONE_ANSWER;
          valid_nxt = 1'b1;
        end
      end
      Q_ID_SEND: begin
        data_nxt = ID_STRING[8*(ID_CHARS-1-int'(idx_r)) +: 8];
        valid_nxt = 1'b1;
      end
      default: begin
        data_nxt = data_r;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      data_r <= DATA_RESET;
      valid_r <= 1'b0;
    end else begin
      data_r <= data_nxt;
      valid_r <= valid_nxt;
    end
  end

  assign event_status_register = evt_r;
  assign event_enable_mask = mask_r;
  assign service_request_enable = req_en_r;
  assign event_summary_bit = |(evt_r & mask_r);
  assign service_request = event_summary_bit && req_en_r[BIT_SUMMARY];
  assign reply_data = data_r;
  assign reply_valid = valid_r;
  assign bus_busy = (st_r != Q_IDLE);
  assign clear_others = clr_r;
endmodule

// *** rtl/event_status_pkg.sv ***
// Purpose: Constants for the standard event status logic.
// Assumes: Single 100 MHz clock, synchronous active-low reset.
// Notes: Bit positions follow the event status register layout.
package event_status_pkg;
  localparam int EVT_W = 8;
  localparam int BIT_DONE = 0;
  localparam int BIT_DDE = 3;
  localparam int BIT_EXE = 4;
  localparam int BIT_CME = 5;
  localparam int BIT_POWER_ON = 7;
  localparam int BIT_SUMMARY = 5;
  localparam logic [7:0] EVT_RESET = 8'h80;
  localparam logic [7:0] EVT_USED = 8'hB9;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] REQ_EN_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [4:0] IDX_RESET = 5'h00;
  localparam logic [7:0] DONE_ANSWER = 8'h01;
  localparam int ID_CHARS = 16;
  typedef enum logic [1:0] {
    Q_IDLE = 2'b00,
    Q_DONE_WAIT = 2'b01,
    Q_ID_SEND = 2'b10
  } query_state_t;
endpackage

// *** tb/event_status_checker_assertions.sv ***
// Purpose: Port checks for the event status logic.
// Assumes: One clock with a synchronous active-low reset.
// Notes: Bound to every instance of the block.
module event_status_checker
  import event_status_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ops_done,
  input wire logic read_status,
  input wire logic complete_clear_cmd,
  input wire logic clear_status_command,
  input wire logic reply_valid,
  input wire logic bus_busy,
  input wire logic clear_others,
  input wire logic event_summary_bit,
  input wire logic service_request,
  input wire logic [7:0] event_status_register,
  input wire logic [7:0] event_enable_mask,
  input wire logic [7:0] service_request_enable,
  input wire logic [7:0] reply_data
);
  wire logic [7:0] status = event_status_register;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_read_reply: assert property (read_status && !bus_busy |=>
    reply_valid && reply_data == $past(status)) else $error("read reply wrong");
  a_done_set: assert property (ops_done |=> status[BIT_DONE]) else $error("flag not set");
  a_power_set: assert property ($rose(reset_n) |-> status[BIT_POWER_ON]) else $error("power bit low");
  a_summary_mask: assert property (event_summary_bit == |(status & event_enable_mask)) else $error("summary");
  a_done_clear: assert property (complete_clear_cmd && !ops_done |=> !status[BIT_DONE]) else $error("flag not clear");
  a_clear_pulse: assert property (clear_status_command |=> clear_others) else $error("no clear pulse");
  a_sticky_bit: assert property (status[BIT_DDE] && !read_status && !clear_status_command |=>
    status[BIT_DDE]) else $error("bit dropped");
  a_clear_read: assert property (read_status && !bus_busy && !ops_done |=> !status[BIT_DONE]) else $error("not cleared");
  a_request_gate: assert property (service_request == (event_summary_bit && service_request_enable[BIT_SUMMARY]))
    else $error("request gate");
endmodule
bind standard_event_status_logic event_status_checker event_status_checker_inst (.*);

// *** tb/host_model.sv ***
// Purpose: Host that clears the flag, starts an operation and polls.
// Assumes: Runs on the bench clock.
// Notes: The operation ends dly cycles after go.
module host_model (
  input wire logic clk, go,
  input wire logic [3:0] dly,
  output logic complete_clear_cmd = 1'b0, complete_query = 1'b0, ops_done = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] n = 4'h0;
  always @(posedge clk) begin
    n <= go ? 4'h1 : (n != 4'h0 && n < dly) ? n + 4'h1 : 4'h0;
    complete_clear_cmd <= n == 4'h1;
    complete_query <= n == 4'h2;
    ops_done <= n == dly;
  end
endmodule

// *** tb/standard_event_status_logic_tb.sv ***
// Purpose: Self-checking bench for the event status logic.
// Assumes: 100 MHz clock, reset held 16 cycles.
// Notes: One task per scenario.
module standard_event_status_logic_tb;
  import event_status_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, reset_n = 1'b0, go = 1'b0, dev_error = 1'b0, exec_error = 1'b0, cmd_error = 1'b0;
  localparam logic [8*ID_CHARS-1:0] ID_EXPECT = "MAKER,M1,SN1,V1 ";
  logic read_status = 1'b0, id_query = 1'b0, clear_status_command = 1'b0, mask_write = 1'b0;
  logic request_enable_write = 1'b0;
  logic [7:0] mask_data = 8'h09, request_enable_data = 8'h20, event_status_register, event_enable_mask, reply_data;
  logic [7:0] service_request_enable;
  logic [3:0] dly = 4'h3;
  logic complete_clear_cmd, complete_query, ops_done, event_summary_bit, service_request, reply_valid, bus_busy;
  logic clear_others;
  int fails = 0, samples_checked = 0, cyc = 0;
  standard_event_status_logic standard_event_status_logic_inst (.*);
  host_model host_model_inst (.*);
  initial forever #5 clk = ~clk;
  task test_done;
    $display("checked %0d failed %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(string n, logic [7:0] e, logic [7:0] s);
    samples_checked++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task rd(logic [7:0] e);
    @(posedge clk) read_status <= 1'b1;
    @(posedge clk) read_status <= 1'b0;
    #1 chk("valid", 8'h01, {7'h00, reply_valid});
    chk("status", e, reply_data);
    chk("cleared", 8'h00, event_status_register);
  endtask
  task t_err;
    @(posedge clk) {mask_write, request_enable_write, dev_error, exec_error, cmd_error} <= 5'h1F;
    @(posedge clk) {mask_write, request_enable_write, dev_error, exec_error, cmd_error} <= 5'h00;
    @(posedge clk) #1 chk("request", 8'h01, {7'h00, service_request});
    chk("summary", 8'h01, {7'h00, event_summary_bit});
    chk("mask", 8'h09, event_enable_mask);
    chk("request enable", 8'h20, service_request_enable);
    rd(8'h38);
  endtask
  task t_opc(logic [3:0] d, logic c);
    @(posedge clk) {dly, go, clear_status_command} <= {d, 1'b1, c};
    @(posedge clk) {go, clear_status_command} <= 2'h0;
    #1 chk("clear pulse", {7'h00, c}, {7'h00, clear_others});
    repeat (3) @(posedge clk);
    #1 chk("busy flag", 8'h02, {6'h00, bus_busy, event_status_register[0]});
    for (int i = 0; i < 20 && reply_valid !== 1'b1; i++) @(posedge clk) #1;
    chk("answer", DONE_ANSWER, reply_data);
    chk("request", 8'h01, {7'h00, service_request});
  endtask
  task t_id;
    @(posedge clk) id_query <= 1'b1;
    @(posedge clk) id_query <= 1'b0;
    for (int i = 0; i < ID_CHARS; i++) begin
      @(posedge clk) #1 chk("id byte", ID_EXPECT[8*(ID_CHARS-1-i) +: 8], reply_data);
      chk("id valid", 8'h01, {7'h00, reply_valid});
    end
    chk("busy after id", 8'h00, {7'h00, bus_busy});
  endtask
  initial begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    rd(EVT_RESET);
    t_err;
    t_opc(4'h3, 1'b1);
    t_opc(4'hC, 1'b0);
    t_id;
    test_done;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 500) begin
      fails++;
      test_done;
    end
  end
endmodule
